//--- verilog/ulr_cfg.svh
// Shared constants of the ULPI register access ends.
`ifndef ULR_CFG_SVH
`define ULR_CFG_SVH
// ---------------------------------------------------------------
// Command byte layout
// ---------------------------------------------------------------
`define ULR_CLS_MSB 7
`define ULR_CLS_LSB 6
`define ULR_ADDR_MSB 5
`define ULR_TXSUB_MSB 5
`define ULR_TXSUB_LSB 4
`define ULR_PID_MSB 3
`define ULR_CLS_TX 2'h1
`define ULR_CLS_WR 2'h2
`define ULR_CLS_RD 2'h3
`define ULR_EXT_ADDR 6'h2f
`define ULR_IDLE_BYTE 8'h00
// ---------------------------------------------------------------
// Register array and status
// ---------------------------------------------------------------
`define ULR_REG_DEPTH 256
`define ULR_REG_RESET 8'h00
`define ULR_STAT_W 7
`endif

//--- verilog/ulr_pkg.sv
// Types shared by the ULPI register access ends.
`include "ulr_cfg.svh"
package ulr_pkg;
  typedef enum logic [3:0] {
    P_IDLE, P_ACK, P_W_HOLD, P_W_EADDR, P_W_DATA, P_W_STP,
    P_R_HOLD, P_R_EADDR, P_R_DIR, P_R_DRIVE, P_R_END, P_TURN,
    P_X_DIR, P_TX_HOLD, P_TX, P_TX_END
  } ulr_phy_state_e;
  typedef enum logic [2:0] {
    L_IDLE, L_CMD, L_EADDR, L_WDATA, L_STP, L_RADDR, L_RWAIT, L_BUSY
  } ulr_link_state_e;
  typedef struct packed {
    ulr_phy_state_e state;
    logic [7:0] cmd;
    logic ext;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic dir;
    logic nxt;
    logic oe;
    logic [7:0] dout;
    logic [`ULR_STAT_W-1:0] s1;
    logic [`ULR_STAT_W-1:0] s2;
    logic [`ULR_STAT_W-1:0] s3;
    logic [`ULR_STAT_W-1:0] stat;
    logic pend;
    logic tx_start;
    logic tx_nopid;
    logic [3:0] tx_pid;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_end;
  } ulr_phy_st_s;
  typedef struct packed {
    ulr_link_state_e state;
    logic have;
    logic wr;
    logic ext;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] dout;
    logic oe;
    logic stp;
    logic dir_q;
    logic done;
    logic [7:0] rdata;
    logic rx_valid;
    logic [7:0] rx_data;
  } ulr_link_st_s;
  typedef struct packed {
    logic [`ULR_REG_DEPTH-1:0][7:0] mem;
  } ulr_regs_st_s;
endpackage

//--- verilog/ulr_ulpi_if.sv
// ULPI bus between the transceiver end and the link end.
`timescale 1ns/1ps
interface ulr_ulpi_if;
  logic [7:0] phy_data;
  logic phy_oe;
  logic [7:0] link_data;
  logic link_oe;
  logic dir;
  logic nxt;
  logic stp;
  logic [7:0] data;
  // Resolved bus level; an undriven turnaround cycle reads as zero.
  assign data = phy_oe ? phy_data : (link_oe ? link_data : 8'h00);
  modport phy (output phy_data, phy_oe, dir, nxt, input data, stp);
  modport link (output link_data, link_oe, stp, input data, dir, nxt);
endinterface

//--- verilog/ulr_regs.sv
// Register array of the transceiver, one byte per address.
`timescale 1ns/1ps
`include "ulr_cfg.svh"
module ulr_regs
  import ulr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  ulr_regs_st_s st;
  ulr_regs_st_s next_st;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Only reset clears the array; no mode change touches it.
  always_comb begin
    next_st = st;
    if (wr_en_in) begin
      next_st.mem[wr_addr_in] = wr_data_in;
    end
  end

  // Reset loads every entry with the documented reset value.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st.mem <= {`ULR_REG_DEPTH{`ULR_REG_RESET}};
    end else begin
      st <= next_st;
    end
  end

  // Read side is a plain mux; the caller registers it.
  assign rd_data_out = st.mem[rd_addr_in];
endmodule

//--- verilog/ulr_phy.sv
// Transceiver end: command decode, register access and receive commands.
`timescale 1ns/1ps
`include "ulr_cfg.svh"
module ulr_phy
  import ulr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  ulr_ulpi_if.phy ulpi,
  input wire logic [1:0] linestate_in,
  input wire logic [1:0] vbus_state_in,
  input wire logic [1:0] rx_event_in,
  input wire logic id_in,
  output logic tx_start_out,
  output logic tx_nopid_out,
  output logic [3:0] tx_pid_out,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic tx_end_out
);
  ulr_phy_st_s st;
  ulr_phy_st_s next_st;
  logic [7:0] rd_data;
  logic commit;
  logic chg;
  logic [1:0] cls;
  logic [`ULR_STAT_W-1:0] stat_raw;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  assign stat_raw = {id_in, rx_event_in, vbus_state_in, linestate_in};
  assign cls = st.cmd[`ULR_CLS_MSB:`ULR_CLS_LSB];
  // A status change counts once the second and third stages agree.
  assign chg = (st.s2 == st.s3) && (st.s3 != st.stat);
  // The write lands on the edge that sees stop high, so the register
  // shows the new value only once stop has dropped.
  assign commit = (st.state == P_W_STP) && ulpi.stp;

  ulr_regs u_regs (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(commit),
    .wr_addr_in(st.addr),
    .wr_data_in(st.wdata),
    .rd_addr_in(st.addr),
    .rd_data_out(rd_data)
  );

  // ---------------------------------------------------------------
  // Protocol state machine
  // ---------------------------------------------------------------
  // One step per rising edge; the bus value seen is the one driven
  // during the cycle just ended.
  always_comb begin
    next_st = st;
    next_st.s1 = stat_raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.tx_start = 1'b0;
    next_st.tx_valid = 1'b0;
    next_st.tx_end = 1'b0;
    if (chg) begin
      next_st.stat = st.s3;
      next_st.pend = 1'b1;
    end
    case (st.state)
      P_IDLE: begin
        // A command that is already on the bus wins over a pending
        // status byte; otherwise the link would lose its command.
        if (ulpi.data != `ULR_IDLE_BYTE) begin
          next_st.cmd = ulpi.data;
          next_st.state = P_ACK;
        end else if (st.pend && !ulpi.stp) begin
          next_st.dir = 1'b1;
          next_st.state = P_X_DIR;
        end
      end
      P_ACK: begin
        next_st.ext = st.cmd[`ULR_ADDR_MSB:0] == `ULR_EXT_ADDR;
        next_st.addr = {2'h0, st.cmd[`ULR_ADDR_MSB:0]};
        next_st.nxt = 1'b1;
        next_st.state = P_IDLE;
        if (cls == `ULR_CLS_WR) begin
          next_st.state = P_W_HOLD;
        end else if (cls == `ULR_CLS_RD) begin
          next_st.state = next_st.ext ? P_R_HOLD : P_R_DIR;
        end else if (cls == `ULR_CLS_TX &&
                     st.cmd[`ULR_TXSUB_MSB:`ULR_TXSUB_LSB] == 2'h0) begin
          next_st.tx_start = 1'b1;
          next_st.tx_pid = st.cmd[`ULR_PID_MSB:0];
          next_st.tx_nopid = st.cmd[`ULR_PID_MSB:0] == 4'h0;
          next_st.state = P_TX_HOLD;
        end else begin
          next_st.nxt = 1'b0;
        end
      end
      P_W_HOLD: begin
        next_st.state = st.ext ? P_W_EADDR : P_W_DATA;
      end
      P_W_EADDR: begin
        next_st.addr = ulpi.data;
        next_st.state = P_W_DATA;
      end
      P_W_DATA: begin
        next_st.wdata = ulpi.data;
        next_st.nxt = 1'b0;
        next_st.state = P_W_STP;
      end
      P_W_STP: begin
        // Direction never rises during a write.
        if (ulpi.stp) begin
          next_st.state = P_IDLE;
        end
      end
      P_R_HOLD: begin
        next_st.state = P_R_EADDR;
      end
      P_R_EADDR: begin
        next_st.addr = ulpi.data;
        next_st.dir = 1'b1;
        next_st.nxt = 1'b0;
        next_st.state = P_R_DRIVE;
      end
      P_R_DIR: begin
        next_st.dir = 1'b1;
        next_st.nxt = 1'b0;
        next_st.state = P_R_DRIVE;
      end
      P_R_DRIVE: begin
        // The cycle after direction rises is the turnaround, so the
        // drive starts only now.
        next_st.oe = 1'b1;
        next_st.dout = rd_data;
        next_st.state = P_R_END;
      end
      P_R_END: begin
        next_st.dir = 1'b0;
        next_st.oe = 1'b0;
        next_st.state = P_TURN;
      end
      P_TURN: begin
        // Bus content in the turnaround is undefined and not looked at.
        next_st.state = P_IDLE;
      end
      P_X_DIR: begin
        // The byte carries the status of this moment; a change seen in
        // the same cycle keeps the pending flag for one more byte.
        next_st.oe = 1'b1;
        next_st.dout = {1'b0, st.stat};
        next_st.pend = chg;
        next_st.state = P_R_END;
      end
      P_TX_HOLD: begin
        next_st.state = P_TX;
      end
      P_TX: begin
        if (ulpi.stp) begin
          next_st.nxt = 1'b0;
          next_st.tx_end = 1'b1;
          next_st.state = P_TX_END;
        end else begin
          next_st.tx_valid = 1'b1;
          next_st.tx_data = ulpi.data;
        end
      end
      P_TX_END: begin
        // Status bytes stay blocked until stop has gone low again.
        if (!ulpi.stp) begin
          next_st.state = P_IDLE;
        end
      end
      default: begin
        next_st.state = P_IDLE;
      end
    endcase
  end

  // All state moves on the rising edge only.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign ulpi.dir = st.dir;
  assign ulpi.nxt = st.nxt;
  assign ulpi.phy_oe = st.oe;
  assign ulpi.phy_data = st.dout;
  assign tx_start_out = st.tx_start;
  assign tx_nopid_out = st.tx_nopid;
  assign tx_pid_out = st.tx_pid;
  assign tx_valid_out = st.tx_valid;
  assign tx_data_out = st.tx_data;
  assign tx_end_out = st.tx_end;
endmodule

//--- verilog/ulr_link.sv
// Link end: issues register writes and reads, collects status bytes.
`timescale 1ns/1ps
`include "ulr_cfg.svh"
module ulr_link
  import ulr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  ulr_ulpi_if.link ulpi,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [7:0] req_addr_in,
  input wire logic [7:0] req_wdata_in,
  output logic req_ready_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic rxcmd_valid_out,
  output logic [7:0] rxcmd_out
);
  ulr_link_st_s st;
  ulr_link_st_s next_st;
  logic bus_free;
  logic start;
  logic s_wr;
  logic s_ext;
  logic [7:0] s_addr;

  // ---------------------------------------------------------------
  // Request intake
  // ---------------------------------------------------------------
  // The bus is ours only after direction has been low for a full cycle.
  assign bus_free = !ulpi.dir && !st.dir_q;
  assign req_ready_out = (st.state == L_IDLE) && !st.have && bus_free;
  assign start = (st.state == L_IDLE) && bus_free &&
                 (st.have || req_valid_in);
  assign s_wr = st.have ? st.wr : req_write_in;
  assign s_addr = st.have ? st.addr : req_addr_in;
  // Address 2Fh and anything above six bits needs the extended form.
  assign s_ext = (s_addr[7:6] != 2'h0) ||
                 (s_addr[`ULR_ADDR_MSB:0] == `ULR_EXT_ADDR);

  // ---------------------------------------------------------------
  // Bus state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.dir_q = ulpi.dir;
    next_st.done = 1'b0;
    next_st.rx_valid = 1'b0;
    // Owned cycles past the turnaround with next low are status bytes, except the read byte taken in L_RWAIT.
    if (ulpi.dir && st.dir_q && !ulpi.nxt && st.state != L_RWAIT) begin
      next_st.rx_valid = 1'b1;
      next_st.rx_data = ulpi.data;
    end
    case (st.state)
      L_IDLE: begin
        next_st.dout = `ULR_IDLE_BYTE;
        next_st.oe = !ulpi.dir;
        if (start) begin
          next_st.have = 1'b1;
          next_st.wr = s_wr;
          next_st.ext = s_ext;
          next_st.addr = s_addr;
          if (!st.have) begin
            next_st.wdata = req_wdata_in;
          end
          next_st.dout = {s_wr ? `ULR_CLS_WR : `ULR_CLS_RD,
                          s_ext ? `ULR_EXT_ADDR : s_addr[`ULR_ADDR_MSB:0]};
          next_st.oe = 1'b1;
          next_st.state = L_CMD;
        end else if (ulpi.dir) begin
          next_st.state = L_BUSY;
        end
      end
      L_CMD: begin
        if (ulpi.dir) begin
          // The transceiver took the bus first; retry afterwards.
          next_st.oe = 1'b0;
          next_st.state = L_BUSY;
        end else if (ulpi.nxt) begin
          if (st.wr) begin
            next_st.dout = st.ext ? st.addr : st.wdata;
            next_st.state = st.ext ? L_EADDR : L_WDATA;
          end else if (st.ext) begin
            next_st.dout = st.addr;
            next_st.state = L_RADDR;
          end else begin
            next_st.oe = 1'b0;
            next_st.state = L_RWAIT;
          end
        end
      end
      L_EADDR: begin
        next_st.dout = st.wdata;
        next_st.state = L_WDATA;
      end
      L_WDATA: begin
        if (ulpi.nxt) begin
          next_st.dout = `ULR_IDLE_BYTE;
          next_st.stp = 1'b1;
          next_st.state = L_STP;
        end
      end
      L_STP: begin
        next_st.stp = 1'b0;
        next_st.done = 1'b1;
        next_st.have = 1'b0;
        next_st.state = L_IDLE;
      end
      L_RADDR: begin
        if (ulpi.nxt) begin
          next_st.oe = 1'b0;
          next_st.state = L_RWAIT;
        end
      end
      L_RWAIT: begin
        // Skip the turnaround, then take the first owned byte.
        if (ulpi.dir && st.dir_q) begin
          next_st.rdata = ulpi.data;
          next_st.done = 1'b1;
          next_st.have = 1'b0;
          next_st.state = L_BUSY;
        end
      end
      L_BUSY: begin
        next_st.oe = 1'b0;
        if (!ulpi.dir) begin
          next_st.dout = `ULR_IDLE_BYTE;
          next_st.oe = 1'b1;
          next_st.state = L_IDLE;
        end
      end
      default: begin
        next_st.state = L_IDLE;
      end
    endcase
  end

  // All state moves on the rising edge only.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Drive is cut the moment direction rises, so the turnaround after
  // a take-over is undriven without waiting for an edge.
  assign ulpi.link_oe = st.oe && !ulpi.dir;
  assign ulpi.link_data = st.dout;
  assign ulpi.stp = st.stp;
  assign done_out = st.done;
  assign rdata_out = st.rdata;
  assign rxcmd_valid_out = st.rx_valid;
  assign rxcmd_out = st.rx_data;
endmodule

//--- bench/ulr_checker.sv
// Protocol checker watching the ULPI bus between the two ends.
`timescale 1ns/1ps
module ulr_checker (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [7:0] phy_data_in,
  input wire logic phy_oe_in,
  input wire logic [7:0] link_data_in,
  input wire logic link_oe_in,
  input wire logic dir_in,
  input wire logic nxt_in,
  input wire logic stp_in,
  input wire logic [7:0] data_in
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  // ---------------------------------------------------------------
  // Bus ownership and turnaround
  // ---------------------------------------------------------------
  // Ownership follows dir; a turnaround leaves the bus to nobody.
  a_one_driver: assert property (phy_oe_in |-> dir_in && !link_oe_in)
    else $error("transceiver drives without owning the bus");
  a_link_yield: assert property (dir_in |-> !link_oe_in)
    else $error("link drives while direction is high");
  // Once the link drives an owned bus it keeps driving, idle included.
  a_link_hold: assert property (!dir_in && !$past(dir_in) &&
    $past(link_oe_in) |-> link_oe_in)
    else $error("link let go of the bus while owning it");
  a_turn_take: assert property ($rose(dir_in) |->
    !phy_oe_in ##1 (phy_oe_in && data_in == phy_data_in) ##1
    (!dir_in && !phy_oe_in))
    else $error("bad transceiver turnaround or data cycle");
  a_turn_give: assert property ($fell(dir_in) |->
    !link_oe_in ##1 (link_oe_in && data_in == 8'h00 &&
    link_data_in == 8'h00))
    else $error("link did not resume with idle after turnaround");
  // ---------------------------------------------------------------
  // Write handshake
  // ---------------------------------------------------------------
  // Stop is a single pulse and never arrives while the bus is turned.
  a_stp_pulse: assert property (stp_in |-> !dir_in ##1 !stp_in)
    else $error("stop pulse too long or direction high");
  a_stp_nxt: assert property ($rose(stp_in) |->
    $past(nxt_in) && !nxt_in)
    else $error("stop did not coincide with next falling");
  a_idle_write: assert property ($fell(stp_in) |->
    data_in == 8'h00 && $past(data_in) == 8'h00)
    else $error("bus not idle around the end of a write");
  // ---------------------------------------------------------------
  // Next throttle
  // ---------------------------------------------------------------
  // Next only ends through a stop (write) or a direction change (read).
  a_nxt_drop: assert property ($fell(nxt_in) |->
    stp_in || dir_in)
    else $error("next fell without stop or direction");
  a_nxt_owner: assert property (nxt_in |-> !dir_in)
    else $error("next high while transceiver owns bus");
  a_nxt_bound: assert property (nxt_in |-> ##[1:3] !nxt_in)
    else $error("next held longer than an extended write");
endmodule

//--- bench/ulr_bench.sv
// Bench joining both ends and checking register access over the bus.
`timescale 1ns/1ps
module ulpi_register_access_bench;
  import ulr_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} ulr_row_s;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic [1:0] linestate = 2'h0;
  logic [1:0] vbus = 2'h0;
  logic [1:0] rx_event = 2'h0;
  logic id = 1'b0;
  logic req_ready;
  logic done;
  logic rxcmd_valid;
  logic [7:0] rdata;
  logic [7:0] rxcmd;
  logic [7:0] last_rx = 8'h00;
  logic tx_start;
  int n_tx = 0;
  int errors = 0;
  int n_checks = 0;
  // Writes first, then reads of the same places; the last row is untouched.
  ulr_row_s rows [11] = '{'{1'b1, 8'h05, 8'ha5}, '{1'b1, 8'h3f, 8'h3c},
    '{1'b1, 8'h2f, 8'h5a}, '{1'b1, 8'h80, 8'hc3}, '{1'b1, 8'hff, 8'h81},
    '{1'b0, 8'h05, 8'ha5}, '{1'b0, 8'h3f, 8'h3c}, '{1'b0, 8'h2f, 8'h5a},
    '{1'b0, 8'h80, 8'hc3}, '{1'b0, 8'hff, 8'h81}, '{1'b0, 8'h06, 8'h00}};
  // ---------------------------------------------------------------
  // Clock, ends and checker
  // ---------------------------------------------------------------
  always #2.5 clk_sys_in = ~clk_sys_in;
  ulr_ulpi_if u ();
  ulr_phy i_ulr_phy (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .ulpi(u), .linestate_in(linestate), .vbus_state_in(vbus),
    .rx_event_in(rx_event), .id_in(id), .tx_start_out(tx_start),
    .tx_nopid_out(), .tx_pid_out(), .tx_valid_out(), .tx_data_out(),
    .tx_end_out());
  ulr_link i_ulr_link (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .ulpi(u), .req_valid_in(req_valid), .req_write_in(req_write),
    .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_ready_out(req_ready), .done_out(done), .rdata_out(rdata),
    .rxcmd_valid_out(rxcmd_valid), .rxcmd_out(rxcmd));
  ulr_checker i_ulr_checker (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .phy_data_in(u.phy_data), .phy_oe_in(u.phy_oe),
    .link_data_in(u.link_data), .link_oe_in(u.link_oe), .dir_in(u.dir),
    .nxt_in(u.nxt), .stp_in(u.stp), .data_in(u.data));
  // Register traffic must never be taken for a packet transmit.
  always @(posedge clk_sys_in) begin
    if (tx_start === 1'b1) begin
      n_tx <= n_tx + 1;
    end
  end
  // The status pulse lasts one cycle, so keep the latest byte seen.
  always @(posedge clk_sys_in) begin
    if (rxcmd_valid === 1'b1) begin
      last_rx <= rxcmd;
    end
  end
  // ---------------------------------------------------------------
  // Compare and report
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_count(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ---------------------------------------------------------------
  // One request through the link, recording the bus after each edge
  // ---------------------------------------------------------------
  // A status byte may abort and delay a request, so strict bus and
  // latency checks are only made where no status change is pending.
  task automatic xfer(input ulr_row_s r, input bit strict);
    logic [7:0] bus [0:15];
    logic t;
    logic ext;
    int k;
    ext = r.a > 8'h3f || r.a == 8'h2f;
    req_write = r.w;
    req_addr = r.a;
    req_wdata = r.d;
    req_valid = 1'b1;
    t = 1'b0;
    for (k = 0; k < 50 && !t; k++) begin
      t = (req_ready === 1'b1);
      @(posedge clk_sys_in);
      #1;
    end
    req_valid = 1'b0;
    bus[0] = u.data;
    for (k = 1; k < 15 && done !== 1'b1; k++) begin
      @(posedge clk_sys_in);
      #1;
      bus[k] = u.data;
    end
    if (!t || done !== 1'b1) begin
      errors++;
      final_report();
    end
    if (strict) begin
      chk_count(k - 1, ext ? 6 : 5);
      chk_byte(bus[0],
        {r.w ? 2'h2 : 2'h3, ext ? 6'h2f : r.a[5:0]});
      if (ext) chk_byte(bus[3], r.a);
      if (r.w) chk_byte(bus[ext ? 4 : 3], r.d);
      if (!r.w) chk_byte(bus[ext ? 5 : 4], r.d);
    end
    if (!r.w) chk_byte(rdata, r.d);
  endtask
  task automatic wait_rx(input logic [7:0] e);
    int k;
    for (k = 0; k < 40 && last_rx !== e; k++) begin
      @(posedge clk_sys_in);
      #1;
    end
    chk_byte(last_rx, e);
    if (last_rx !== e) final_report();
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys_in);
    #1;
    rst_n_in = 1'b1;
    foreach (rows[i]) xfer(rows[i], 1'b1);
    // Status byte layout: zero, id, event, vbus, line state.
    linestate = 2'h1;
    vbus = 2'h2;
    rx_event = 2'h3;
    id = 1'b1;
    wait_rx(8'h79);
    // A status change racing a read must neither lose it nor the byte.
    // Four edges of synchronising bring the pending byte to the very
    // edge that launches the command, so the link is cut off and retries.
    linestate = 2'h2;
    repeat (4) @(posedge clk_sys_in);
    #1;
    xfer(rows[8], 1'b0);
    wait_rx(8'h7a);
    linestate = 2'h0;
    vbus = 2'h0;
    rx_event = 2'h0;
    id = 1'b0;
    wait_rx(8'h00);
    // Reset mid-run clears the handshakes and the register array.
    rst_n_in = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk_byte({5'h00, u.dir, u.nxt, u.stp}, 8'h00);
    rst_n_in = 1'b1;
    xfer('{1'b0, 8'h05, 8'h00}, 1'b1);
    chk_count(n_tx, 0);
    final_report();
  end
endmodule
